// >>> design/irq_mask_pkg.sv
// shared constants for the interrupt acceptance and masking block
package irq_mask_pkg;
   // ------------------------------------------------------------
   // source layout
   // ------------------------------------------------------------
   localparam int NUM_INPUT = 6;
   localparam int NUM_TIMER = 3;
   localparam int NUM_COUNTER = 6;
   localparam int NUM_SRC = 15;
   localparam int NUM_MASK = 10;
   localparam int ID_W = 4;
   localparam int TIMER_BASE = 6;
   localparam int COUNTER_BASE = 9;
   localparam int MASK_COUNTER_BIT = 9;
   localparam int NUM_EVT = 3;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam int ADR_W = 8;
   localparam logic [7:0] OFS_MASK = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_PENDING = 8'h08;
   localparam logic [7:0] OFS_EVT_STATUS = 8'h0c;
   localparam logic [7:0] OFS_EVT_CLEAR = 8'h10;
   localparam logic [7:0] OFS_EVT_ENABLE = 8'h14;
   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int CTRL_GIE_BIT = 0;
   localparam int CTRL_RUN_BIT = 1;
   localparam int EVT_ACCEPT_BIT = 0;
   localparam int EVT_IGNORE_BIT = 1;
   localparam int EVT_STOP_BIT = 2;
   localparam logic [9:0] RST_MASK = 10'h000;
   localparam logic [14:0] RST_PENDING = 15'h0000;
   localparam logic RST_GIE = 1'b0;
   localparam logic [2:0] RST_EVT = 3'h0;
endpackage : irq_mask_pkg

// >>> design/pin_sync_rise.sv
// two-stage synchroniser with rising edge detect for the input pins
`timescale 1ns/1ps
module pin_sync_rise
   import irq_mask_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [irq_mask_pkg::NUM_INPUT-1:0] pin_i,
   output logic [irq_mask_pkg::NUM_INPUT-1:0] rise_o
);
   import irq_mask_pkg::*;

   typedef struct packed {
      logic [NUM_INPUT-1:0] meta;
      logic [NUM_INPUT-1:0] sync;
      logic [NUM_INPUT-1:0] prev;
   } sync_s;

   sync_s state_reg;
   sync_s state_next;

   always_comb begin
      state_next = state_reg;
      state_next.meta = pin_i;
      state_next.sync = state_reg.meta;
      state_next.prev = state_reg.sync;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // only the second stage and its delayed copy feed the edge detector
   assign rise_o = state_reg.sync & ~state_reg.prev;
endmodule : pin_sync_rise

// >>> design/irq_mask_ctrl.sv
// interrupt acceptance, masking per input and timer source and per counter group, and dispatch with wishbone registers
`timescale 1ns/1ps
module irq_mask_ctrl
   import irq_mask_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [irq_mask_pkg::ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   output logic irq_o,
   input wire logic run_mode_i,
   input wire logic global_irq_enable_instr_i,
   input wire logic global_irq_disable_instr_i,
   input wire logic [irq_mask_pkg::NUM_INPUT-1:0] input_irq_i,
   input wire logic [irq_mask_pkg::NUM_TIMER-1:0] timer_irq_i,
   input wire logic [irq_mask_pkg::NUM_COUNTER-1:0] counter_irq_i,
   input wire logic serve_take_i,
   output logic serve_valid_o,
   output logic [irq_mask_pkg::ID_W-1:0] serve_id_o
);
   import irq_mask_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // one counter flag covers the whole counter group
   function automatic logic [NUM_SRC-1:0] expand_mask(input logic [NUM_MASK-1:0] m);
      logic [NUM_SRC-1:0] e;
      e = '0;
      e[COUNTER_BASE-1:0] = m[COUNTER_BASE-1:0];
      e[NUM_SRC-1:COUNTER_BASE] = {NUM_COUNTER{m[MASK_COUNTER_BIT]}};
      return e;
   endfunction : expand_mask

   // lowest source number wins
   function automatic logic [ID_W-1:0] first_set(input logic [NUM_SRC-1:0] v);
      logic [ID_W-1:0] id;
      id = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            id = ID_W'(i);
         end
      end
      return id;
   endfunction : first_set

   function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge_sel

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NUM_MASK-1:0] mask;
      logic [NUM_SRC-1:0] pend;
      logic gie;
      logic run_prev;
      logic serve_valid;
      logic [ID_W-1:0] serve_id;
      logic [NUM_EVT-1:0] evt_stat;
      logic [NUM_EVT-1:0] evt_en;
      logic ack;
      logic [31:0] dat;
   } state_s;

   state_s r;
   state_s n;

   logic [NUM_INPUT-1:0] input_rise;
   logic [NUM_SRC-1:0] src_req;
   logic [NUM_SRC-1:0] exp_mask;
   logic [NUM_SRC-1:0] accept_v;
   logic [NUM_SRC-1:0] ignore_v;
   logic [NUM_SRC-1:0] taken_v;
   logic run_to_stop;
   logic bus_wr;

   // pins come from outside the clock domain
   pin_sync_rise u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(input_irq_i),
      .rise_o(input_rise)
   );

   assign src_req = {counter_irq_i, timer_irq_i, input_rise};
   assign exp_mask = expand_mask(r.mask);
   assign run_to_stop = r.run_prev & ~run_mode_i;
   // the write lands on the edge where the master sees ack
   assign bus_wr = cyc_i & stb_i & we_i & r.ack;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic [NUM_SRC-1:0] eligible;
      logic [31:0] rd;
      eligible = '0;
      rd = '0;
      n = r;
      n.run_prev = run_mode_i;

      // acceptance: a masked request is dropped, not deferred
      ignore_v = src_req & exp_mask;
      accept_v = src_req & ~exp_mask;
      taken_v = '0;
      if (serve_take_i && r.serve_valid) begin
         taken_v[r.serve_id] = 1'b1;
      end
      // a new request in the dispatch cycle survives the clear
      n.pend = (r.pend & ~taken_v) | accept_v;

      // global enable follows the core's instructions; disable wins a tie
      if (global_irq_enable_instr_i) begin
         n.gie = 1'b1;
      end
      if (global_irq_disable_instr_i) begin
         n.gie = 1'b0;
      end

      // register writes
      if (bus_wr) begin
         case (adr_i)
            OFS_MASK: begin
               n.mask = NUM_MASK'(merge_sel(32'(r.mask), dat_i, sel_i));
            end
            OFS_EVT_ENABLE: begin
               n.evt_en = NUM_EVT'(merge_sel(32'(r.evt_en), dat_i, sel_i));
            end
            default: begin
            end
         endcase
      end
      if (run_to_stop) begin
         n.mask = RST_MASK;
      end

      // dispatch offer is re-evaluated every cycle from the new state
      eligible = n.pend & ~expand_mask(n.mask);
      n.serve_valid = n.gie & (|eligible);
      n.serve_id = first_set(eligible);

      // sticky events; a fresh event beats a clear in the same cycle
      if (bus_wr && adr_i == OFS_EVT_CLEAR) begin
         n.evt_stat = r.evt_stat & ~NUM_EVT'(dat_i[NUM_EVT-1:0] & {NUM_EVT{sel_i[0]}});
      end
      n.evt_stat[EVT_ACCEPT_BIT] = n.evt_stat[EVT_ACCEPT_BIT] | (|accept_v);
      n.evt_stat[EVT_IGNORE_BIT] = n.evt_stat[EVT_IGNORE_BIT] | (|ignore_v);
      n.evt_stat[EVT_STOP_BIT] = n.evt_stat[EVT_STOP_BIT] | run_to_stop;

      // bus answer: one wait state, unmapped reads return zero
      n.ack = cyc_i & stb_i & ~r.ack;
      case (adr_i)
         OFS_MASK: rd = 32'(r.mask);
         OFS_CTRL: begin
            rd[CTRL_GIE_BIT] = r.gie;
            rd[CTRL_RUN_BIT] = r.run_prev;
         end
         OFS_PENDING: rd = 32'(r.pend);
         OFS_EVT_STATUS: rd = 32'(r.evt_stat);
         OFS_EVT_ENABLE: rd = 32'(r.evt_en);
         default: rd = '0;
      endcase
      n.dat = (cyc_i & stb_i & ~r.ack & ~we_i) ? rd : '0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r.mask <= RST_MASK;
         r.pend <= RST_PENDING;
         r.gie <= RST_GIE;
         r.run_prev <= 1'b0;
         r.serve_valid <= 1'b0;
         r.serve_id <= '0;
         r.evt_stat <= RST_EVT;
         r.evt_en <= RST_EVT;
         r.ack <= 1'b0;
         r.dat <= '0;
      end else begin
         r <= n;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign ack_o = r.ack;
   assign dat_o = r.dat;
   assign serve_valid_o = r.serve_valid;
   assign serve_id_o = r.serve_id;
   assign irq_o = |(r.evt_stat & r.evt_en);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [NUM_SRC-1:0] blocked_new;
   logic [NUM_SRC-1:0] counter_blocked;
   assign blocked_new = src_req & exp_mask & ~r.pend;
   assign counter_blocked = {counter_irq_i & {NUM_COUNTER{r.mask[MASK_COUNTER_BIT]}}, 9'h000} & ~r.pend;

   a_masked_not_pended: assert property (@(posedge clk_i) disable iff (rst_i)
      (blocked_new != '0) |=> ((r.pend & $past(blocked_new)) == '0))
      else $error("masked request became pending");

   a_mask_beats_gie: assert property (@(posedge clk_i) disable iff (rst_i)
      r.serve_valid |-> !exp_mask[r.serve_id])
      else $error("masked source offered for service");

   a_group0_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      (input_rise[0] && r.mask[0] && !r.pend[0]) |=> !r.pend[0])
      else $error("group zero accepted while masked");

   a_accept_pends: assert property (@(posedge clk_i) disable iff (rst_i)
      (accept_v != '0) |=> ((r.pend & $past(accept_v)) == $past(accept_v)))
      else $error("unmasked request not recorded");

   a_enabled_dispatch: assert property (@(posedge clk_i) disable iff (rst_i)
      (global_irq_enable_instr_i && !global_irq_disable_instr_i && !serve_take_i
       && ((r.pend & ~exp_mask) != '0) && !bus_wr && !run_to_stop) |=> r.serve_valid)
      else $error("enabled pending interrupt not offered");

   a_disabled_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      (!r.gie) |-> !r.serve_valid)
      else $error("service offered while globally disabled");

   a_counter_group_mask: assert property (@(posedge clk_i) disable iff (rst_i)
      (counter_blocked != '0) |=> ((r.pend & $past(counter_blocked)) == '0))
      else $error("counter interrupt accepted while masked");

   a_stop_clears_mask: assert property (@(posedge clk_i) disable iff (rst_i)
      run_to_stop |=> (r.mask == '0) ##1 (r.evt_stat[EVT_STOP_BIT] || $past(bus_wr)))
      else $error("mask flags not cleared on run to stop");

   a_take_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      (serve_take_i && r.serve_valid && ((accept_v & taken_v) == '0))
      |=> ((r.pend & $past(taken_v)) == '0))
      else $error("pending bit not cleared on dispatch");

   a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      ((r.evt_stat & r.evt_en) != '0) |-> irq_o)
      else $error("interrupt output low with enabled event");

   // ------------------------------------------------------------
   // bus, dispatch, reset, mask write, global enable and event flag checks
   // ------------------------------------------------------------
   // these guard the hand-over contract that the core and the bus master rely on
   logic [NUM_SRC-1:0] lower_v;
   assign lower_v = (NUM_SRC'(1) << r.serve_id) - NUM_SRC'(1);

   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held for more than one cycle");

   a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o)
      else $error("bus request not answered in one cycle");

   a_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !ack_o |-> (dat_o == '0))
      else $error("read data driven outside ack");

   a_reset_quiet: assert property (@(posedge clk_i)
      rst_i |=> (!ack_o && !serve_valid_o && r.mask == '0 && r.pend == '0 && !r.gie))
      else $error("state not cleared by reset");

   a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (bus_wr && adr_i == OFS_MASK && sel_i == 4'hf && !run_to_stop) |=> (r.mask == $past(dat_i[NUM_MASK-1:0])))
      else $error("mask write did not land");

   a_id_in_range: assert property (@(posedge clk_i) disable iff (rst_i)
      serve_valid_o |-> (serve_id_o < ID_W'(NUM_SRC)))
      else $error("offered source number out of range");

   a_offer_pending: assert property (@(posedge clk_i) disable iff (rst_i)
      serve_valid_o |-> r.pend[r.serve_id])
      else $error("offered source has no pending bit");

   a_lowest_first: assert property (@(posedge clk_i) disable iff (rst_i)
      serve_valid_o |-> ((r.pend & ~exp_mask & lower_v) == '0))
      else $error("lower numbered source passed over");

   a_enable_sets_gie: assert property (@(posedge clk_i) disable iff (rst_i)
      (global_irq_enable_instr_i && !global_irq_disable_instr_i) |=> r.gie)
      else $error("enable instruction did not set global enable");

   a_disable_drops: assert property (@(posedge clk_i) disable iff (rst_i)
      global_irq_disable_instr_i |=> (!r.gie && !r.serve_valid))
      else $error("disable instruction did not withdraw the offer");

   a_ignore_event: assert property (@(posedge clk_i) disable iff (rst_i)
      (ignore_v != '0) |=> r.evt_stat[EVT_IGNORE_BIT])
      else $error("dropped request not flagged");

   a_accept_event: assert property (@(posedge clk_i) disable iff (rst_i)
      (accept_v != '0) |=> r.evt_stat[EVT_ACCEPT_BIT])
      else $error("accepted request not flagged");

   a_stop_event: assert property (@(posedge clk_i) disable iff (rst_i)
      run_to_stop |=> r.evt_stat[EVT_STOP_BIT])
      else $error("run to stop not flagged");

   a_stop_keeps_pend: assert property (@(posedge clk_i) disable iff (rst_i)
      (run_to_stop && !serve_take_i) |=> ((r.pend & $past(r.pend)) == $past(r.pend)))
      else $error("pending bits lost on run to stop");

   a_irq_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      ((r.evt_stat & r.evt_en) == '0) |-> !irq_o)
      else $error("interrupt output high with no enabled event");

   c_served: cover property (@(posedge clk_i) disable iff (rst_i) serve_take_i && r.serve_valid);
   c_counter_served: cover property (@(posedge clk_i) disable iff (rst_i)
      serve_take_i && r.serve_valid && (r.serve_id >= ID_W'(COUNTER_BASE)));
   c_ignored: cover property (@(posedge clk_i) disable iff (rst_i) ignore_v != '0);
   c_stop: cover property (@(posedge clk_i) disable iff (rst_i) run_to_stop && r.mask != '0);
   c_held_then_run: cover property (@(posedge clk_i) disable iff (rst_i)
      (!r.gie && r.pend != '0) ##1 global_irq_enable_instr_i ##1 r.serve_valid);
endmodule : irq_mask_ctrl

// >>> verification/core_model.sv
// behavioural model of the processor core that takes offered interrupts
`timescale 1ns/1ps
module core_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic valid_i,
   input wire logic [3:0] id_i,
   output logic take_o,
   output logic [3:0] last_id_o,
   output logic [7:0] count_o
);
   // ------------------------------------------------------------
   // dispatch
   // ------------------------------------------------------------
   // go_i low lets the bench model a slow core that leaves offers standing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         take_o <= 1'b0;
         last_id_o <= 4'h0;
         count_o <= 8'h00;
      end else begin
         if (take_o && valid_i) begin
            last_id_o <= id_i;
            count_o <= count_o + 8'h01;
         end
         take_o <= go_i && valid_i && !take_o;
      end
   end
endmodule : core_model

// >>> verification/interrupt_source_masking_bench.sv
// self-checking bench for the interrupt masking block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   $display("[FAIL] %s expected %h seen %h", n, e, g); n_errors++; end end
module interrupt_source_masking_bench;
   import irq_mask_pkg::*;
   logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, ack, irq, run = 0, ei = 0, di = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [3:0] sel = 4'h0, sid, lid;
   logic [5:0] pin = 6'h0, cnt_irq = 6'h0;
   logic [2:0] tmr = 3'h0;
   logic svalid, take, go = 0;
   logic [7:0] ntk;
   int n_errors = 0, checks_done = 0;
   always #50 clk_i = ~clk_i;
   irq_mask_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .we_i(we),
      .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .irq_o(irq), .run_mode_i(run),
      .global_irq_enable_instr_i(ei), .global_irq_disable_instr_i(di), .input_irq_i(pin),
      .timer_irq_i(tmr), .counter_irq_i(cnt_irq), .serve_take_i(take), .serve_valid_o(svalid),
      .serve_id_o(sid));
   core_model i_core (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .valid_i(svalid), .id_i(sid),
      .take_o(take), .last_id_o(lid), .count_o(ntk));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
      do begin @(posedge clk_i); t++; end while (ack !== 1'b1 && t < 50);
      q = rdat;
      cyc <= 0; stb <= 0; we <= 0;
      if (t >= 50) begin
         n_errors++;
         end_sim();
      end
   endtask : wb
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
      wb(a, 1'b0, 32'h0);
      `CHK(n, e, q)
   endtask : rd_chk
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wt
   task automatic end_sim();
      if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   initial begin
      wt(5000);
      n_errors++;
      end_sim();
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      wt(5);
      rst_i <= 0;
      rd_chk(OFS_MASK, 32'h0, "mask reset");
      rd_chk(OFS_CTRL, 32'h0, "ctrl reset");
      rd_chk(8'h1c, 32'h0, "unmapped");
      wb(OFS_MASK, 1, 32'hffff_ffff);
      rd_chk(OFS_MASK, 32'h3ff, "mask width");
      wb(OFS_MASK, 1, 32'h0);
      go <= 1; ei <= 1; wt(1); ei <= 0; tmr <= 3'h1; wt(1); tmr <= 3'h0; wt(4);
      `CHK("taken count", 8'h01, ntk)
      `CHK("taken id", 4'h6, lid)
      rd_chk(OFS_PENDING, 32'h0, "pend cleared");
      // pin edge while group zero masked, with global enable on
      wb(OFS_MASK, 1, 32'h1);
      pin <= 6'h01; wt(8);
      `CHK("masked pin", 8'h01, ntk)
      rd_chk(OFS_PENDING, 32'h0, "masked pend");
      rd_chk(OFS_EVT_STATUS, 32'h3, "evt ignored");
      pin <= 6'h00;
      wb(OFS_MASK, 1, 32'h200);
      cnt_irq <= 6'h21; wt(1); cnt_irq <= 6'h00; wt(4);
      `CHK("masked counter", 8'h01, ntk)
      rd_chk(OFS_PENDING, 32'h0, "counter pend");
      wb(OFS_MASK, 1, 32'h0);
      di <= 1; wt(1); di <= 0; cnt_irq <= 6'h20; wt(1); cnt_irq <= 6'h00; wt(4);
      `CHK("held offer", 1'b0, svalid)
      rd_chk(OFS_PENDING, 32'h4000, "held pend");
      ei <= 1; wt(1); ei <= 0; wt(4);
      `CHK("resumed count", 8'h02, ntk)
      `CHK("resumed id", 4'he, lid)
      // event interrupt: masked by enable, raised, then cleared
      `CHK("irq disabled", 1'b0, irq)
      wb(OFS_EVT_ENABLE, 1, 32'h2); wt(1);
      `CHK("irq raised", 1'b1, irq)
      wb(OFS_EVT_CLEAR, 1, 32'h2); wt(1);
      `CHK("irq cleared", 1'b0, irq)
      run <= 1;
      wb(OFS_MASK, 1, 32'h3ff);
      run <= 0; wt(2);
      rd_chk(OFS_MASK, 32'h0, "stop clears");
      rd_chk(OFS_EVT_STATUS, 32'h5, "stop event");
      end_sim();
   end
endmodule : interrupt_source_masking_bench
